// ==== verilog/cisc_pkg.sv ====
/*
 * Shared constants, types and helpers for the channel input-select control block.
 * Assumes a single 50 MHz APB clock domain; nothing here holds state.
 */
package cisc_pkg;

    // Register byte offsets
    localparam logic [7:0] ADDR_CHAN_ONE = 8'h00;
    localparam logic [7:0] ADDR_CHAN_TWO = 8'h04;
    localparam logic [7:0] ADDR_RATE_CFG = 8'h08;
    localparam logic [7:0] ADDR_TEST_CFG = 8'h0c;
    localparam logic [7:0] ADDR_STATUS = 8'h10;

    // Channel settings fields
    localparam int SEL_LSB = 0;
    localparam int SEL_W = 4;
    localparam int GAIN_LSB = 4;
    localparam int GAIN_W = 3;
    localparam logic [6:0] CHAN_RESET = 7'h00;

    // Rate configuration fields
    localparam int RATE_LSB = 0;
    localparam int RATE_W = 3;
    localparam int HS_BIT = 3;
    localparam logic [3:0] RATE_RESET = 4'h0;
    localparam logic [2:0] RATE_MAX = 3'h6;

    // Test configuration fields
    localparam int TEN_BIT = 0;
    localparam int TFREQ_BIT = 1;
    localparam logic [1:0] TEST_RESET = 2'h0;

    // Status field positions
    localparam int ST_SEL1_LSB = 0;
    localparam int ST_GAIN1_LSB = 4;
    localparam int ST_SEL2_LSB = 8;
    localparam int ST_GAIN2_LSB = 12;
    localparam int ST_RATE_LSB = 16;
    localparam int ST_RUN_BIT = 20;
    localparam int ST_TEST_BIT = 21;

    // Clock figures
    localparam longint CLK_HZ = 50_000_000;
    localparam longint OSC_HZ = 512_000;
    localparam int ACC_W = 26;
    localparam logic [ACC_W-1:0] ACC_WRAP = ACC_W'(CLK_HZ);
    localparam logic [ACC_W-1:0] ACC_STEP = ACC_W'(OSC_HZ);
    localparam int OSC_GAP_CYCLES = int'(CLK_HZ / OSC_HZ);

    // Slowest output rates, samples per second
    localparam longint HR_BASE_SPS = 125;
    localparam longint HS_BASE_SPS = 250;
    localparam int PER_W = 13;
    localparam int HR_BASE_TICKS = int'(OSC_HZ / HR_BASE_SPS);
    localparam int HS_BASE_TICKS = int'(OSC_HZ / HS_BASE_SPS);

    // Test signal half periods in oscillator ticks
    localparam int TST_W = 20;
    localparam int TEST_SLOW_HALF = 1 << 20;
    localparam int TEST_FAST_HALF = 1 << 19;

    // Selector codes
    typedef enum logic [3:0] {
        SRC_NORMAL = 4'h0,
        SRC_SHORTED = 4'h1,
        SRC_AUX = 4'h2,
        SRC_SUPPLY = 4'h3,
        SRC_TEST = 4'h5
    } cisc_src_t;

    typedef enum logic {
        CONV_IDLE = 1'b0,
        CONV_RUN = 1'b1
    } cisc_conv_state_t;

    // One-hot switch enables for one channel
    typedef struct packed {
        logic normal;
        logic shorted;
        logic aux_single;
        logic supply_monitor;
        logic test;
    } cisc_route_t;

    // Applied settings of one channel
    typedef struct packed {
        cisc_route_t route;
        logic [2:0] gain_code;
        logic [3:0] gain_value;
    } cisc_chan_t;

    function automatic logic cisc_sel_valid(input logic [3:0] s);
        return s inside {SRC_NORMAL, SRC_SHORTED, SRC_AUX, SRC_SUPPLY, SRC_TEST};
    endfunction : cisc_sel_valid

    function automatic logic [3:0] cisc_gain_value(input logic [2:0] c);
        case (c)
            3'h0: return 4'h1;
            3'h1: return 4'h2;
            3'h2: return 4'h3;
            3'h3: return 4'h4;
            3'h4: return 4'h6;
            3'h5: return 4'h8;
            3'h6: return 4'hc;
            default: return 4'h0;
        endcase
    endfunction : cisc_gain_value

endpackage : cisc_pkg

// ==== verilog/cisc_top.sv ====
/*
 * Channel input-select control: APB register file, per-channel routing and
 * gain decode, data-rate timing from a 512 kHz oscillator tick, test signal.
 * Assumes pclk at 50 MHz and a start input already synchronous to pclk.
 */
// Decided for this implementation: the register addresses and the APB register port.
`timescale 1ns/1ps

// Applies one channel's settings; reserved codes keep the last valid value
module cisc_chan
    import cisc_pkg::*;
(
    input wire logic pclk, // Bus clock
    input wire logic presetn, // Async reset, active low
    input wire logic [6:0] settings, // Channel settings register
    output cisc_chan_t applied // Applied routing and gain
);
    logic [3:0] sel;
    logic [2:0] gain;
    logic [3:0] sel_raw;
    logic [2:0] gain_raw;
    logic [3:0] next_sel;
    logic [2:0] next_gain;

    assign sel_raw = settings[SEL_LSB +: SEL_W];
    assign gain_raw = settings[GAIN_LSB +: GAIN_W];
    assign next_sel = cisc_sel_valid(sel_raw) ? sel_raw : sel;
    assign next_gain = (cisc_gain_value(gain_raw) != 4'h0) ? gain_raw : gain;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sel <= SRC_NORMAL;
            gain <= 3'h0;
        end else begin
            sel <= next_sel;
            gain <= next_gain;
        end
    end

    assign applied.route.normal = (sel == SRC_NORMAL);
    assign applied.route.shorted = (sel == SRC_SHORTED);
    assign applied.route.aux_single = (sel == SRC_AUX);
    assign applied.route.supply_monitor = (sel == SRC_SUPPLY);
    assign applied.route.test = (sel == SRC_TEST);
    assign applied.gain_code = gain;
    assign applied.gain_value = cisc_gain_value(gain);
endmodule : cisc_chan

// What this block does
// - each channel takes its routing from its own settings register, independently
// - selector 0001 shorts both channel inputs to mid-reference
// - selector 0101 routes the internal test signal onto the channel
// - test signal exists only when enabled, toggling at the chosen rate
// - selector 0011 routes the channel-specific supply monitor
// - selector 0010 measures auxiliary single input against mid-supply
// - seven gain codes give gains 1, 2, 3, 4, 6, 8, 12
// - test source shared; each channel keeps own input pair
// - high-speed rate code 000 gives 250, doubling to 16000 at 110
// - high-resolution rate code 000 gives 125, doubling to 8000 at 110
// - internal 512 kHz oscillator clocks the conversions
// - start pin aligns conversions across devices sharing it
module cisc_top
    import cisc_pkg::*;
#(
    parameter int TEST_SLOW_HALF_TICKS = TEST_SLOW_HALF, // Slow test half period
    parameter int TEST_FAST_HALF_TICKS = TEST_FAST_HALF // Fast test half period
) (
    input wire logic pclk, // 50 MHz bus clock
    input wire logic presetn, // Async reset, active low
    input wire logic psel, // APB select
    input wire logic penable, // APB enable
    input wire logic pwrite, // APB write
    input wire logic [7:0] paddr, // APB byte address
    input wire logic [31:0] pwdata, // APB write data
    output logic [31:0] prdata, // APB read data
    output logic pready, // APB ready
    output logic pslverr, // APB error
    input wire logic start, // Conversion start pin
    output cisc_chan_t chan_one, // Channel 1 applied settings
    output cisc_chan_t chan_two, // Channel 2 applied settings
    output logic test_signal_positive, // Shared test source, plus side
    output logic test_signal_negative, // Shared test source, minus side
    output logic osc_tick, // 512 kHz oscillator tick
    output logic conv_strobe, // Sample-ready pulse
    output logic high_speed // Applied power mode
);
    logic [6:0] channel_one_settings;
    logic [6:0] channel_two_settings;
    logic [3:0] rate_configuration;
    logic [1:0] test_reference_configuration;
    logic [2:0] data_rate_code;
    logic [ACC_W-1:0] osc_acc;
    logic [PER_W-1:0] conv_cnt;
    logic [TST_W-1:0] test_cnt;
    logic start_d;
    cisc_conv_state_t conv_state;

    // APB decode; no wait states, error on unmapped or status write
    logic setup;
    logic access;
    logic wr_en;
    logic mapped;
    logic [31:0] rd_value;
    logic [31:0] status_word;
    assign setup = psel && !penable;
    assign access = psel && penable;
    assign mapped = paddr inside {ADDR_CHAN_ONE, ADDR_CHAN_TWO, ADDR_RATE_CFG,
                                  ADDR_TEST_CFG, ADDR_STATUS};
    assign pready = 1'b1;
    assign pslverr = access && (!mapped || (pwrite && paddr == ADDR_STATUS));
    assign wr_en = access && pwrite && !pslverr;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            channel_one_settings <= CHAN_RESET;
            channel_two_settings <= CHAN_RESET;
            rate_configuration <= RATE_RESET;
            test_reference_configuration <= TEST_RESET;
        end else if (wr_en) begin
            if (paddr == ADDR_CHAN_ONE) channel_one_settings <= pwdata[6:0];
            if (paddr == ADDR_CHAN_TWO) channel_two_settings <= pwdata[6:0];
            if (paddr == ADDR_RATE_CFG) rate_configuration <= pwdata[3:0];
            if (paddr == ADDR_TEST_CFG) test_reference_configuration <= pwdata[1:0];
        end
    end

    // Read data captured in setup so it stands through access
    // Route codes go in as arguments so the word follows every route change
    assign status_word = {10'h000, test_signal_positive, conv_state == CONV_RUN,
                          high_speed, data_rate_code, 1'b0, chan_two.gain_code,
                          route_code(chan_two.route), 1'b0, chan_one.gain_code,
                          route_code(chan_one.route)};
    assign rd_value = (paddr == ADDR_CHAN_ONE) ? {25'h0, channel_one_settings} :
                      (paddr == ADDR_CHAN_TWO) ? {25'h0, channel_two_settings} :
                      (paddr == ADDR_RATE_CFG) ? {28'h0, rate_configuration} :
                      (paddr == ADDR_TEST_CFG) ? {30'h0, test_reference_configuration} :
                      (paddr == ADDR_STATUS) ? status_word : 32'h0;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) prdata <= 32'h0;
        else if (setup) prdata <= pwrite ? 32'h0 : rd_value;
    end

    function automatic logic [3:0] route_code(input cisc_route_t r);
        return r.shorted ? SRC_SHORTED : r.aux_single ? SRC_AUX :
               r.supply_monitor ? SRC_SUPPLY : r.test ? SRC_TEST : SRC_NORMAL;
    endfunction : route_code

    cisc_chan u_chan_one (
        .pclk(pclk),
        .presetn(presetn),
        .settings(channel_one_settings),
        .applied(chan_one)
    );
    cisc_chan u_chan_two (
        .pclk(pclk),
        .presetn(presetn),
        .settings(channel_two_settings),
        .applied(chan_two)
    );

    // reserved rate code keeps previous rate
    logic [2:0] next_rate;
    assign next_rate = (rate_configuration[RATE_LSB +: RATE_W] <= RATE_MAX) ?
                       rate_configuration[RATE_LSB +: RATE_W] : data_rate_code;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            data_rate_code <= 3'h0;
            high_speed <= 1'b0;
        end else begin
            data_rate_code <= next_rate;
            high_speed <= rate_configuration[HS_BIT];
        end
    end

    // fractional 512 kHz tick; 50 MHz is no integer multiple
    logic [ACC_W-1:0] acc_sum;
    logic acc_over;
    assign acc_sum = osc_acc + ACC_STEP;
    assign acc_over = acc_sum >= ACC_WRAP;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            osc_acc <= '0;
            osc_tick <= 1'b0;
        end else begin
            osc_acc <= acc_over ? acc_sum - ACC_WRAP : acc_sum;
            osc_tick <= acc_over;
        end
    end

    // period in ticks halves per code step
    logic [PER_W-1:0] period;
    logic [PER_W-1:0] base_ticks;
    assign base_ticks = high_speed ? PER_W'(HS_BASE_TICKS) : PER_W'(HR_BASE_TICKS);
    assign period = base_ticks >> data_rate_code;

    // start rise restarts the count so shared starts line up
    logic start_rise;
    logic conv_end;
    assign start_rise = start && !start_d;
    assign conv_end = osc_tick && (conv_cnt == period - PER_W'(1));
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            start_d <= 1'b0;
            conv_state <= CONV_IDLE;
            conv_cnt <= '0;
            conv_strobe <= 1'b0;
        end else begin
            start_d <= start;
            conv_strobe <= 1'b0;
            case (conv_state)
                CONV_IDLE: begin
                    conv_cnt <= '0;
                    if (start_rise) conv_state <= CONV_RUN;
                end
                CONV_RUN: begin
                    if (!start) begin
                        conv_state <= CONV_IDLE;
                        conv_cnt <= '0;
                    end else if (conv_end) begin
                        conv_cnt <= '0;
                        conv_strobe <= 1'b1;
                    end else if (osc_tick) begin
                        conv_cnt <= conv_cnt + PER_W'(1);
                    end
                end
                default: conv_state <= CONV_IDLE;
            endcase
        end
    end

    // test square wave only while enabled
    logic [TST_W-1:0] test_half;
    assign test_half = test_reference_configuration[TFREQ_BIT] ?
                       TST_W'(TEST_FAST_HALF_TICKS - 1) : TST_W'(TEST_SLOW_HALF_TICKS - 1);
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            test_cnt <= '0;
            test_signal_positive <= 1'b0;
        end else if (!test_reference_configuration[TEN_BIT]) begin
            test_cnt <= '0;
            test_signal_positive <= 1'b0;
        end else if (osc_tick) begin
            test_cnt <= (test_cnt >= test_half) ? '0 : test_cnt + TST_W'(1);
            if (test_cnt >= test_half) test_signal_positive <= !test_signal_positive;
        end
    end
    // Minus side is the complement only while the source is live
    assign test_signal_negative = test_reference_configuration[TEN_BIT] &&
                                  !test_signal_positive;

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    property p_apb_ready;
        access && pwrite && paddr == ADDR_STATUS |-> pready && pslverr;
    endproperty
    a_apb_ready: assert property (p_apb_ready) else $error("apb not ready");
    property p_indep;
        wr_en && paddr == ADDR_CHAN_ONE |=> $stable(channel_two_settings);
    endproperty
    a_indep: assert property (p_indep) else $error("channel two disturbed");
    property p_short;
        channel_one_settings[SEL_LSB +: SEL_W] == SRC_SHORTED |=> chan_one.route.shorted;
    endproperty
    a_short: assert property (p_short) else $error("short not applied");
    property p_test_route;
        channel_two_settings[SEL_LSB +: SEL_W] == SRC_TEST |=> chan_two.route.test;
    endproperty
    a_test_route: assert property (p_test_route) else $error("test not routed");
    property p_test_off;
        !test_reference_configuration[TEN_BIT] |-> !test_signal_negative
            ##1 !test_signal_positive;
    endproperty
    a_test_off: assert property (p_test_off) else $error("test live while off");
    property p_supply;
        channel_one_settings[SEL_LSB +: SEL_W] == SRC_SUPPLY |=> chan_one.route.supply_monitor;
    endproperty
    a_supply: assert property (p_supply) else $error("supply not routed");
    property p_aux;
        channel_two_settings[SEL_LSB +: SEL_W] == SRC_AUX |=> chan_two.route.aux_single;
    endproperty
    a_aux: assert property (p_aux) else $error("aux not routed");
    property p_gain;
        chan_one.gain_value inside {4'h1, 4'h2, 4'h3, 4'h4, 4'h6, 4'h8, 4'hc};
    endproperty
    a_gain: assert property (p_gain) else $error("illegal gain");
    property p_rate;
        high_speed && data_rate_code == 3'h6 |-> period == PER_W'(32);
    endproperty
    a_rate: assert property (p_rate) else $error("fastest rate wrong");
    property p_rate_hr;
        !high_speed && data_rate_code == 3'h0 |-> period == PER_W'(4096);
    endproperty
    a_rate_hr: assert property (p_rate_hr) else $error("slowest rate wrong");
    property p_osc_gap;
        osc_tick |=> !osc_tick [*8];
    endproperty
    a_osc_gap: assert property (p_osc_gap) else $error("oscillator too fast");
    property p_start;
        start_rise |=> conv_cnt == '0 && conv_state == CONV_RUN;
    endproperty
    a_start: assert property (p_start) else $error("start did not align");
    property p_reserved;
        rate_configuration[RATE_LSB +: RATE_W] == 3'h7 |=> $stable(data_rate_code);
    endproperty
    a_reserved: assert property (p_reserved) else $error("reserved rate applied");

    c_strobe: cover property (conv_strobe);
    c_test_toggle: cover property ($rose(test_signal_positive));
    c_both_routes: cover property (chan_one.route.test && chan_two.route.supply_monitor);
endmodule : cisc_top

// ==== testbench/cisc_top_tb.sv ====
/*
 * Self-checking bench for cisc_top: routing table, rates, test signal, APB errors.
 * Assumes the design package is compiled first; zero-wait APB slave at 50 MHz.
 */
`timescale 1ns/1ps

`define CHK(g, e) begin compares++; if ((g) !== (e)) begin fails++; \
    $display("BAD t=%0t got=%h exp=%h", $time, g, e); end end

module cisc_top_tb;
    import cisc_pkg::*;

    typedef struct packed {
        logic ch;
        logic [3:0] sel;
        logic [2:0] gc;
        cisc_chan_t exp;
    } cisc_row_t;

    localparam logic [4:0] RN = 5'h10;
    localparam logic [4:0] RS = 5'h08;
    localparam logic [4:0] RA = 5'h04;
    localparam logic [4:0] RM = 5'h02;
    localparam logic [4:0] RT = 5'h01;
    localparam int LIMIT = 90000;

    // Each row: channel, code written, applied settings expected on that channel
    cisc_row_t rows [13] = '{
        {1'b0, 4'h1, 3'h1, RS, 3'h1, 4'h2}, {1'b1, 4'h5, 3'h2, RT, 3'h2, 4'h3},
        {1'b0, 4'h3, 3'h0, RM, 3'h0, 4'h1}, {1'b1, 4'h2, 3'h3, RA, 3'h3, 4'h4},
        {1'b0, 4'h2, 3'h4, RA, 3'h4, 4'h6}, {1'b1, 4'h3, 3'h0, RM, 3'h0, 4'h1},
        {1'b0, 4'h5, 3'h5, RT, 3'h5, 4'h8}, {1'b1, 4'h1, 3'h6, RS, 3'h6, 4'hc},
        {1'b0, 4'h4, 3'h5, RT, 3'h5, 4'h8}, {1'b1, 4'h1, 3'h7, RS, 3'h6, 4'hc},
        {1'b0, 4'hf, 3'h5, RT, 3'h5, 4'h8}, {1'b0, 4'h0, 3'h6, RN, 3'h6, 4'hc},
        {1'b1, 4'h0, 3'h0, RN, 3'h0, 4'h1}};

    logic pclk;
    logic presetn;
    logic psel;
    logic penable;
    logic pwrite;
    logic [7:0] paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic start;
    cisc_chan_t chan_one;
    cisc_chan_t chan_two;
    logic test_signal_positive;
    logic test_signal_negative;
    logic osc_tick;
    logic conv_strobe;
    logic high_speed;
    int fails = 0;
    int compares = 0;
    int cycles = 0;
    cisc_chan_t e1;
    cisc_chan_t e2;
    logic [31:0] rd;
    logic err;
    int n;

    // Short test half periods keep the run brief
    cisc_top #(.TEST_SLOW_HALF_TICKS(4), .TEST_FAST_HALF_TICKS(2)) dut_u (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .start(start), .chan_one(chan_one),
        .chan_two(chan_two), .test_signal_positive(test_signal_positive),
        .test_signal_negative(test_signal_negative), .osc_tick(osc_tick),
        .conv_strobe(conv_strobe), .high_speed(high_speed));

    initial begin
        pclk = 1'b0;
        forever #10 pclk = ~pclk;
    end

    task automatic end_of_test();
        if (fails == 0 && compares > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : end_of_test

    // Hang guard: a stuck wait ends as a failure
    always @(posedge pclk) begin
        cycles <= cycles + 1;
        if (cycles == LIMIT) begin
            fails++;
            end_of_test();
        end
    end

    // One APB transfer; request held until pready is sampled high
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    // Ticks between two pulses of conv_strobe; first interval discarded
    task automatic strobe_ticks(output int t);
        do @(posedge pclk); while (conv_strobe !== 1'b1);
        t = 0;
        do begin
            @(posedge pclk);
            if (osc_tick === 1'b1) t++;
        end while (conv_strobe !== 1'b1);
    endtask : strobe_ticks

    // Ticks between two successive toggles of the test signal
    task automatic toggle_ticks(output int t);
        logic p;
        p = test_signal_positive;
        do @(posedge pclk); while (test_signal_positive === p);
        p = test_signal_positive;
        t = 0;
        do begin
            @(posedge pclk);
            if (osc_tick === 1'b1) t++;
        end while (test_signal_positive === p);
    endtask : toggle_ticks

    // Rate restart: stop, program, restart, measure one full period
    task automatic rate_run(input logic hs, input logic [2:0] code);
        start <= 1'b0;
        apb(1'b1, ADDR_RATE_CFG, {28'h0, hs, code});
        start <= 1'b1;
        strobe_ticks(n);
    endtask : rate_run

    function automatic int want_ticks(input logic hs, input int code);
        return 512000 / ((hs ? 250 : 125) << code);
    endfunction : want_ticks

    initial begin
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        start = 1'b0;
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        // Reset values of the four writable registers, of chan_one and of the test outputs
        for (int i = 0; i < 4; i++) begin
            apb(1'b0, 8'(i * 4), 32'h0);
            `CHK(rd, 32'h0)
        end
        `CHK(chan_one, cisc_chan_t'({RN, 3'h0, 4'h1}))
        `CHK({test_signal_positive, test_signal_negative}, 2'b00)
        e1 = chan_one;
        e2 = chan_two;
        // Routing table, both channels watched after every write
        foreach (rows[i]) begin
            apb(1'b1, rows[i].ch ? ADDR_CHAN_TWO : ADDR_CHAN_ONE,
                {25'h0, rows[i].gc, rows[i].sel});
            `CHK(err, 1'b0)
            if (rows[i].ch) e2 = rows[i].exp;
            else e1 = rows[i].exp;
            repeat (3) @(posedge pclk);
            `CHK(chan_one, e1)
            `CHK(chan_two, e2)
        end
        apb(1'b0, ADDR_CHAN_ONE, 32'h0);
        `CHK(rd, 32'h60)
        apb(1'b0, ADDR_STATUS, 32'h0);
        `CHK(rd[14:0], 15'h0060)
        // Refused accesses: unmapped read, write to read-only status
        apb(1'b0, 8'h14, 32'h0);
        `CHK({err, rd}, {1'b1, 32'h0})
        apb(1'b1, ADDR_STATUS, 32'hffff_ffff);
        `CHK(err, 1'b1)
        do @(posedge pclk); while (osc_tick !== 1'b1);
        n = 0;
        for (int k = 0; k < 16; k++) begin
            do begin
                @(posedge pclk);
                n++;
            end while (osc_tick !== 1'b1);
            if (k == 0) `CHK(n inside {97, 98}, 1'b1)
        end
        `CHK(n inside {1562, 1563}, 1'b1)
        rate_run(1'b1, 3'h6);
        `CHK(n, want_ticks(1'b1, 6))
        `CHK(high_speed, 1'b1)
        rate_run(1'b1, 3'h5);
        `CHK(n, want_ticks(1'b1, 5))
        rate_run(1'b0, 3'h6);
        `CHK(n, want_ticks(1'b0, 6))
        `CHK(high_speed, 1'b0)
        // reserved rate code keeps the last period
        rate_run(1'b0, 3'h7);
        `CHK(n, want_ticks(1'b0, 6))
        rate_run(1'b1, 3'h6);
        start <= 1'b0;
        n = 0;
        repeat (4000) begin
            @(posedge pclk);
            if (conv_strobe === 1'b1) n++;
        end
        `CHK(n, 0)
        apb(1'b1, ADDR_TEST_CFG, 32'h1);
        toggle_ticks(n);
        `CHK(n, 4)
        `CHK(test_signal_negative, ~test_signal_positive)
        apb(1'b1, ADDR_TEST_CFG, 32'h3);
        toggle_ticks(n);
        toggle_ticks(n);
        `CHK(n, 2)
        apb(1'b1, ADDR_TEST_CFG, 32'h0);
        repeat (400) @(posedge pclk);
        `CHK({test_signal_positive, test_signal_negative}, 2'b00)
        // Second reset in mid-run returns routing to normal inputs
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        `CHK(chan_one, cisc_chan_t'({RN, 3'h0, 4'h1}))
        `CHK(conv_strobe, 1'b0)
        presetn <= 1'b1;
        repeat (2) @(posedge pclk);
        apb(1'b0, ADDR_STATUS, 32'h0);
        `CHK(rd, 32'h0)
        apb(1'b0, ADDR_CHAN_ONE, 32'h0);
        `CHK(rd, 32'h0)
        end_of_test();
    end

endmodule : cisc_top_tb
